// ===== shared/cmal_pkg.sv
// constants, command codes and carriers for the mode and address logic
package cmal_pkg;

  // address widths and masks
  localparam int ADDR_W = 24;
  localparam logic [23:0] NORM_ADDR_MASK = 24'h00ffff;
  localparam logic [23:0] ADV_ADDR_MASK = 24'hffffff;
  localparam logic [23:0] VEC_BASE = 24'h000000;
  localparam logic [23:0] IND_AREA_MASK = 24'h0000ff;
  localparam logic [7:0] ADV_RSVD_TOP = 8'h00;
  localparam int VEC_SHIFT_NORM = 1;
  localparam int VEC_SHIFT_ADV = 2;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0002;

  // condition code and extended control layout
  localparam int CCR_I_BIT = 7;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [7:0] EXR_RESET = 8'h7f;
  localparam logic [7:0] EXR_ONES = 8'h78;

  // execution states
  localparam int UMUL_B_STATES = 12;
  localparam int UMUL_W_STATES = 20;
  localparam int SMUL_B_STATES = 13;
  localparam int SMUL_W_STATES = 21;
  localparam int MAX_CLK_MHZ = 20;
  localparam int ADD_TIME_NS = 50;
  localparam int ALU_STATES = ADD_TIME_NS * MAX_CLK_MHZ / 1000;
  localparam int SYS_CLK_MHZ = 50;
  localparam int CNT_W = 5;
  localparam int DIV_W = 5;

  // instruction classes handed to the block
  typedef enum logic [3:0] {
    OP_NOP,
    OP_JMP_IND,
    OP_JSR_IND,
    OP_JSR,
    OP_RTS,
    OP_EXCEPT,
    OP_RTE,
    OP_UMUL_B,
    OP_UMUL_W,
    OP_SMUL_B,
    OP_SMUL_W,
    OP_ALU,
    OP_STEP,
    OP_SLEEP,
    OP_LDCCR,
    OP_ACCUM
  } cmal_op_type;

  // command from the instruction decoder
  typedef struct packed {
    cmal_op_type op;
    logic [7:0] abs8;
    logic [7:0] vec;
    logic [23:0] pc;
    logic [31:0] reg_val;
    logic [2:0] step;
    logic dec;
  } cmal_cmd_type;

  // memory word request
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cmal_mem_type;

  // result of a finished command
  typedef struct packed {
    logic done;
    logic illegal;
    logic [23:0] pc;
    logic [31:0] reg_val;
    logic [23:0] ea;
  } cmal_res_type;

endpackage

// ===== src/cmal_addr_unit.sv
// effective address step and mode masking for a general register
`timescale 1ns/1ps
`default_nettype none
module cmal_addr_unit
  import cmal_pkg::*;
(
  // operand
  input wire logic [31:0] reg_val_i,
  input wire logic [2:0] step_i,
  input wire logic dec_i,
  input wire logic advanced_i,
  // results
  output logic [31:0] new_val_o,
  output logic [23:0] ea_o
);
  logic [31:0] step_ext;
  logic [31:0] sum;
  logic [23:0] raw_ea;

  // full width step so a carry or borrow reaches the upper half
  assign step_ext = {29'h0, step_i};
  assign sum = dec_i ? reg_val_i - step_ext : reg_val_i + step_ext;
  assign new_val_o = sum;

  // pre-decrement addresses with the new value, post-increment with old
  assign raw_ea = dec_i ? sum[23:0] : reg_val_i[23:0];
  assign ea_o = advanced_i ? (raw_ea & ADV_ADDR_MASK)
                           : (raw_ea & NORM_ADDR_MASK);
endmodule
`default_nettype wire

// ===== src/cmal_core.sv
// mode selection, stack, indirect branch and timing sequencer of the core
`timescale 1ns/1ps
`default_nettype none
// Operation
// - mode comes from mode pins only
// - normal mode reaches at most 64 kbytes
// - normal mode uses low 16 address bits
// - step carry propagates into upper half
// - normal vectors: 16-bit entries from zero
// - indirect branch: 8-bit address, word target
// - normal indirect operands within 0 to ff
// - call pushes pc; exception pc and ccr
// - advanced mode: 16-Mbyte linear space
// - upper halves usable as independent registers
// - advanced vectors 32 bits, low 24 used
// - advanced indirect longword, top byte zero
// - advanced indirect operands within lowest 256 bytes
// - unsigned multiply: 12 or 20 states
// - signed multiply: 13 or 21 states
// - add and subtract complete in one state
// - no multiply-accumulate register or its instructions
// - sleep enters power-down; clock speed selectable (the selected speed only divides multiply execution states)
// - register seven acts as stack pointer
// - exception entry sets ccr interrupt mask
module cmal_core
  import cmal_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // mode pin and speed
  input wire logic mode_adv_i,
  input wire logic [1:0] speed_sel_i,
  input wire logic wake_i,
  // command
  input wire cmal_pkg::cmal_cmd_type cmd_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  output cmal_pkg::cmal_res_type res_o,
  // memory
  output cmal_pkg::cmal_mem_type mem_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // state
  output logic advanced_o,
  output logic sleep_o,
  output logic [31:0] sp_o,
  output logic [7:0] ccr_o,
  output logic [7:0] exr_o
);
  import cmal_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH,
    ST_FETCH,
    ST_POP,
    ST_EXEC,
    ST_SLEEP
  } cmal_state_type;

  cmal_state_type state_q, state_d;
  logic mode_cap_q, adv_q;
  logic [31:0] sp_q;
  logic [7:0] ccr_q, exr_q;
  cmal_op_type op_q;
  logic [15:0] push_w_q [2];
  logic [1:0] words_q;
  logic word_ix_q;
  logic [23:0] fetch_a_q;
  logic [15:0] hi_w_q;
  logic [CNT_W-1:0] st_cnt_q;
  logic [DIV_W-1:0] div_q;
  cmal_res_type res_q;
  logic [31:0] step_val;
  logic [23:0] step_ea;

  cmal_addr_unit u_addr (
    .reg_val_i(cmd_i.reg_val),
    .step_i(cmd_i.step),
    .dec_i(cmd_i.dec),
    .advanced_i(adv_q),
    .new_val_o(step_val),
    .ea_o(step_ea)
  );

  // command decode
  logic take, is_call, is_exc, is_ind, is_ret, is_mul, is_acc, last_word;
  logic mem_done, state_stb;
  logic [23:0] raw_addr, ind_addr, vec_addr, sp_dec, tgt;
  logic [CNT_W-1:0] mul_states;
  logic [DIV_W-1:0] div_max;
  assign take = cmd_valid_i & cmd_ready_o;
  assign is_call = cmd_i.op == OP_JSR || cmd_i.op == OP_JSR_IND;
  assign is_exc = cmd_i.op == OP_EXCEPT;
  assign is_ind = cmd_i.op == OP_JMP_IND || cmd_i.op == OP_JSR_IND;
  assign is_ret = cmd_i.op == OP_RTS || cmd_i.op == OP_RTE;
  assign is_mul = cmd_i.op inside {OP_UMUL_B, OP_UMUL_W, OP_SMUL_B,
                                   OP_SMUL_W};
  assign is_acc = cmd_i.op == OP_ACCUM;
  assign mul_states =
    cmd_i.op == OP_UMUL_B ? CNT_W'(UMUL_B_STATES) :
    cmd_i.op == OP_UMUL_W ? CNT_W'(UMUL_W_STATES) :
    cmd_i.op == OP_SMUL_B ? CNT_W'(SMUL_B_STATES) :
                            CNT_W'(SMUL_W_STATES);

  // indirect operand stays in the lowest 256 bytes in either mode
  assign ind_addr = {16'h0, cmd_i.abs8} & IND_AREA_MASK;
  assign vec_addr = VEC_BASE | (adv_q ?
    ({16'h0, cmd_i.vec} << VEC_SHIFT_ADV) :
    ({16'h0, cmd_i.vec} << VEC_SHIFT_NORM));

  // stack addressing through register seven
  assign sp_dec = sp_q[23:0] - WORD_BYTES[23:0];
  assign raw_addr = (state_q == ST_PUSH) ? sp_dec :
                    (state_q == ST_POP) ? sp_q[23:0] : fetch_a_q;
  assign mem_o.req = state_q inside {ST_PUSH, ST_FETCH, ST_POP};
  assign mem_o.we = state_q == ST_PUSH;
  assign mem_o.addr = adv_q ? (raw_addr & ADV_ADDR_MASK)
                            : (raw_addr & NORM_ADDR_MASK);
  assign mem_o.wdata = push_w_q[word_ix_q];
  assign mem_done = clk_en_i & mem_o.req & mem_ack_i;
  // one-word transfers end at index 0, two-word transfers at index 1
  assign last_word = word_ix_q == (words_q == 2'd2);

  // branch target from the fetched words; top byte treated as zero
  assign tgt = adv_q ? {hi_w_q[7:0], mem_rdata_i}
                     : {8'h00, mem_rdata_i};

  // state strobe from the selected core clock speed
  assign div_max = DIV_W'((1 << speed_sel_i) - 1);
  assign state_stb = clk_en_i && div_q == div_max;

  assign cmd_ready_o = state_q == ST_IDLE && mode_cap_q;
  assign advanced_o = adv_q;
  assign sleep_o = state_q == ST_SLEEP;
  assign sp_o = sp_q;
  assign ccr_o = ccr_q;
  assign exr_o = exr_q | EXR_ONES;
  assign res_o = res_q;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          if (is_call || is_exc) begin
            state_d = ST_PUSH;
          end else if (is_ind) begin
            state_d = ST_FETCH;
          end else if (is_ret) begin
            state_d = ST_POP;
          end else if (is_mul) begin
            state_d = ST_EXEC;
          end else if (cmd_i.op == OP_SLEEP) begin
            state_d = ST_SLEEP;
          end
        end
      end
      ST_PUSH: begin
        if (mem_done && last_word) begin
          state_d = (op_q == OP_JSR) ? ST_IDLE : ST_FETCH;
        end
      end
      ST_FETCH, ST_POP: begin
        if (mem_done && last_word) begin
          state_d = ST_IDLE;
        end
      end
      ST_EXEC: begin
        if (state_stb && st_cnt_q == CNT_W'(1)) begin
          state_d = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (wake_i) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // mode capture once after reset release
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_cap_q <= 1'b0;
      adv_q <= 1'b0;
    end else if (clk_en_i && !mode_cap_q) begin
      mode_cap_q <= 1'b1;
      adv_q <= mode_adv_i;
    end
  end

  // state, divider and execution state counter
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      div_q <= '0;
      st_cnt_q <= '0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      div_q <= (state_q != ST_EXEC || state_stb) ? '0 : div_q + 1'b1;
      if (take && is_mul) begin
        st_cnt_q <= mul_states;
      end else if (state_q == ST_EXEC && state_stb) begin
        st_cnt_q <= st_cnt_q - 1'b1;
      end
    end
  end

  // command capture: push words, word counts and fetch address
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      op_q <= OP_NOP;
      words_q <= 2'd0;
      word_ix_q <= 1'b0;
      fetch_a_q <= VEC_BASE;
      push_w_q[0] <= 16'h0;
      push_w_q[1] <= 16'h0;
    end else if (clk_en_i) begin
      if (take) begin
        op_q <= cmd_i.op;
        word_ix_q <= 1'b0;
        fetch_a_q <= is_exc ? vec_addr : ind_addr;
        push_w_q[0] <= cmd_i.pc[15:0];
        if (is_exc) begin
          push_w_q[1] <= adv_q ? {ccr_q, cmd_i.pc[23:16]}
                               : {ccr_q, ccr_q};
          words_q <= 2'd2;
        end else if (is_call) begin
          push_w_q[1] <= {ADV_RSVD_TOP, cmd_i.pc[23:16]};
          words_q <= adv_q ? 2'd2 : 2'd1;
        end else begin
          words_q <= (adv_q || cmd_i.op == OP_RTE) ? 2'd2 : 2'd1;
        end
      end else if (mem_done) begin
        word_ix_q <= ~last_word;
        if (state_q == ST_FETCH) begin
          fetch_a_q <= fetch_a_q + WORD_BYTES[23:0];
        end
        if (state_q == ST_PUSH && last_word) begin
          words_q <= adv_q ? 2'd2 : 2'd1;
        end
      end
    end
  end

  // stack pointer and control registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sp_q <= 32'h0;
      ccr_q <= CCR_RESET;
      exr_q <= EXR_RESET;
    end else if (clk_en_i) begin
      if (take && is_exc) begin
        ccr_q[CCR_I_BIT] <= 1'b1;
      end else if (take && cmd_i.op == OP_LDCCR) begin
        ccr_q <= cmd_i.reg_val[7:0];
      end else if (take && cmd_i.op == OP_STEP && cmd_i.step != 3'd0) begin
        sp_q <= sp_q;
      end
      if (mem_done && state_q == ST_PUSH) begin
        sp_q <= sp_q - WORD_BYTES;
      end else if (mem_done && state_q == ST_POP) begin
        sp_q <= sp_q + WORD_BYTES;
        if (op_q == OP_RTE && !word_ix_q) begin
          ccr_q <= mem_rdata_i[15:8];
        end
      end
    end
  end

  // first fetched or popped word is the high half
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hi_w_q <= 16'h0;
    end else if (mem_done && !word_ix_q) begin
      hi_w_q <= mem_rdata_i;
    end
  end

  // results: branch targets, step values and completion pulse
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      res_q <= '0;
    end else if (clk_en_i) begin
      res_q.done <= 1'b0;
      res_q.illegal <= 1'b0;
      if (take && cmd_i.op == OP_STEP) begin
        res_q.reg_val <= step_val;
        res_q.ea <= step_ea;
        res_q.done <= 1'b1;
      end else if (take && cmd_i.op == OP_JSR) begin
        res_q.pc <= adv_q ? cmd_i.pc : (cmd_i.pc & NORM_ADDR_MASK);
      end else if (take && (cmd_i.op == OP_ALU || cmd_i.op == OP_NOP
                            || cmd_i.op == OP_LDCCR)) begin
        res_q.done <= 1'b1;
      end else if (take && is_acc) begin
        res_q.done <= 1'b1;
        res_q.illegal <= 1'b1;
      end
      if (mem_done && last_word && state_q != ST_PUSH) begin
        res_q.pc <= tgt;
        res_q.done <= 1'b1;
      end else if (state_q == ST_PUSH && state_d == ST_IDLE) begin
        res_q.done <= 1'b1;
      end else if (state_q == ST_EXEC && state_d == ST_IDLE) begin
        res_q.done <= 1'b1;
      end else if (state_q == ST_SLEEP && wake_i) begin
        res_q.done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/cmal_core_asserts.sv
// concurrent checks on the ports of the mode and address core
`timescale 1ns/1ps
`default_nettype none
module cmal_core_asserts
  import cmal_pkg::*;
(
  // clock, reset and pins
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic mode_adv_i,
  input wire logic [1:0] speed_sel_i,
  input wire logic wake_i,
  // command side
  input wire cmal_pkg::cmal_cmd_type cmd_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire cmal_pkg::cmal_res_type res_o,
  // memory side
  input wire cmal_pkg::cmal_mem_type mem_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // state
  input wire logic advanced_o,
  input wire logic sleep_o,
  input wire logic [31:0] sp_o,
  input wire logic [7:0] ccr_o,
  input wire logic [7:0] exr_o
);
  // command accepted at this edge
  wire logic take = clk_en_i && cmd_valid_i && cmd_ready_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  norm_addr_a: assert property (
    mem_o.req && !advanced_o |-> mem_o.addr[23:16] == 8'h00)
    else $error("normal mode address above bit 15");
  norm_ea_a: assert property (
    res_o.done && !advanced_o |-> res_o.ea[23:16] == 8'h00)
    else $error("normal mode result address too wide");
  exr_fixed_a: assert property (
    exr_o == EXR_RESET)
    else $error("extended control register changed");
  mode_hold_a: assert property (
    cmd_ready_o && $past(cmd_ready_o) |-> $stable(advanced_o))
    else $error("mode changed while running");
  alu_one_a: assert property (
    take && cmd_i.op == OP_ALU |=> res_o.done)
    else $error("add not done in one state");
  accum_ill_a: assert property (
    take && cmd_i.op == OP_ACCUM |=> res_o.done && res_o.illegal)
    else $error("accumulate not refused");
  ill_done_a: assert property (
    res_o.illegal |-> res_o.done)
    else $error("illegal flag without done");
  sleep_hold_a: assert property (
    sleep_o && !wake_i |=> sleep_o)
    else $error("power-down left without wake");
  mul_min_a: assert property (
    take && cmd_i.op inside {OP_UMUL_B, OP_UMUL_W, OP_SMUL_B, OP_SMUL_W}
    |=> !res_o.done [*8])
    else $error("multiply finished too early");
  ind_fetch_a: assert property (
    take && cmd_i.op == OP_JMP_IND |=> mem_o.req && !mem_o.we &&
    mem_o.addr == {16'h0000, $past(cmd_i.abs8)})
    else $error("indirect operand fetch wrong");
  exc_mask_a: assert property (
    take && cmd_i.op == OP_EXCEPT |=> ccr_o[CCR_I_BIT])
    else $error("exception entry left mask clear");
endmodule
bind cmal_core cmal_core_asserts u_cmal_core_asserts (.*);
`default_nettype wire

// ===== sim/cmal_core_bench.sv
// self-checking bench for the mode and address core
`timescale 1ns/1ps
`default_nettype none
module cmal_core_bench;
  import cmal_pkg::*;
  // design pins
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic mode_adv_i = 1'b0;
  logic [1:0] speed_sel_i = 2'h0;
  logic wake_i = 1'b0;
  cmal_cmd_type cmd_i = '0;
  logic cmd_valid_i = 1'b0;
  logic cmd_ready_o;
  cmal_res_type res_o;
  cmal_mem_type mem_o;
  logic mem_ack_i = 1'b0;
  logic [15:0] mem_rdata_i = 16'h0000;
  logic advanced_o;
  logic sleep_o;
  logic [31:0] sp_o;
  logic [7:0] ccr_o;
  logic [7:0] exr_o;
  int err_total = 0;
  int compares = 0;
  int n;
  logic [15:0] mem [logic [23:0]];

  always #10 sys_clk_i = ~sys_clk_i;
  cmal_core u_cmal_core (.*);

  // word memory: stored words, else a pattern from the address
  function automatic logic [15:0] rd(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : {a[7:0] ^ 8'ha5, a[7:0]};
  endfunction
  always @(negedge sys_clk_i) begin
    mem_ack_i <= mem_o.req;
    mem_rdata_i <= rd(mem_o.addr);
  end
  always @(posedge sys_clk_i) begin
    if (mem_o.req && mem_o.we && mem_ack_i) begin
      mem[mem_o.addr] = mem_o.wdata;
    end
  end

  // comparison and closing
  task automatic chk(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // reset with a mode pin level
  task automatic do_reset(input logic adv);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b1;
    mode_adv_i = adv;
    mem.delete();
    repeat (4) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
  endtask

  // one command, n = cycles after the take cycle until done
  task automatic run(input cmal_op_type op, input logic [7:0] a8,
      input logic [23:0] pc, input logic [31:0] rv, input logic [2:0] st,
      input logic dec);
    @(negedge sys_clk_i); // keep valid low for a cycle between commands
    cmd_i = '{op, a8, a8, pc, rv, st, dec};
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (res_o.done !== 1'b1 && n < 200) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(n < 200, "no answer");
  endtask

  task automatic t_normal;
    do_reset(1'b0);
    chk(advanced_o === 1'b0 && ccr_o === CCR_RESET, "reset mode");
    chk(exr_o === EXR_RESET && sp_o === 32'h0, "reset regs");
    run(OP_JMP_IND, 8'hf0, 24'h0, 32'h0, 3'h0, 1'b0);
    chk(res_o.pc === 24'h0055f0, "normal indirect");
    run(OP_STEP, 8'h0, 24'h0, 32'h1234ffff, 3'h1, 1'b0);
    chk(res_o.reg_val === 32'h12350000, "carry");
    chk(res_o.ea === 24'h00ffff, "post ea");
    run(OP_STEP, 8'h0, 24'h0, 32'h00ab0000, 3'h2, 1'b0 + 1'b1);
    chk(res_o.reg_val === 32'h00aafffe, "borrow");
    chk(res_o.ea === 24'h00fffe, "pre ea");
    run(OP_EXCEPT, 8'h03, 24'h001234, 32'h0, 3'h0, 1'b0);
    chk(mem[24'h00fffe] === 16'h1234, "push pc");
    chk(mem[24'h00fffc] === 16'h8080, "push ccr");
    chk(!mem.exists(24'h00fffa), "extra push");
    chk(res_o.pc === 24'h00a306, "vector");
    chk(sp_o[15:0] === 16'hfffc, "sp after exception");
    chk(ccr_o[CCR_I_BIT] === 1'b1, "mask set");
    run(OP_JSR, 8'h0, 24'h00abcd, 32'h0, 3'h0, 1'b0);
    chk(mem[24'h00fffa] === 16'habcd, "call push");
    chk(!mem.exists(24'h00fff8), "call one word");
    run(OP_RTS, 8'h0, 24'h0, 32'h0, 3'h0, 1'b0);
    chk(res_o.pc === 24'h00abcd, "return");
    chk(sp_o[15:0] === 16'hfffc, "sp after return");
    run(OP_ALU, 8'h0, 24'h0, 32'h0, 3'h0, 1'b0);
    chk(n == ALU_STATES - 1, "add states");
    run(OP_NOP, 8'h0, 24'h0, 32'h0, 3'h0, 1'b0);
    chk(n == ALU_STATES - 1 && res_o.illegal === 1'b0, "nop");
    run(OP_ACCUM, 8'h0, 24'h0, 32'h0, 3'h0, 1'b0);
    chk(res_o.illegal === 1'b1, "accumulate");
    $display("normal mode test over");
  endtask

  task automatic t_adv;
    do_reset(1'b1);
    chk(advanced_o === 1'b1, "advanced mode");
    mode_adv_i = 1'b0; // pin moves after capture, mode must stay
    mem[24'h000040] = 16'hff12;
    mem[24'h000042] = 16'h3456;
    run(OP_JMP_IND, 8'h40, 24'h0, 32'h0, 3'h0, 1'b0);
    chk(res_o.pc === 24'h123456, "long indirect");
    run(OP_STEP, 8'h0, 24'h0, 32'h00ffffff, 3'h1, 1'b0);
    chk(res_o.reg_val === 32'h01000000, "upper half");
    chk(res_o.ea === 24'hffffff, "linear ea");
    run(OP_EXCEPT, 8'h02, 24'h345678, 32'h0, 3'h0, 1'b0);
    chk(mem[24'hfffffe] === 16'h5678, "push pc low");
    chk(mem[24'hfffffc] === 16'h8034, "push ccr pc");
    chk(res_o.pc === 24'h08af0a, "long vector");
    run(OP_JSR, 8'h0, 24'h9abcde, 32'h0, 3'h0, 1'b0);
    chk(mem[24'hfffffa] === 16'hbcde, "call low");
    chk(mem[24'hfffff8] === 16'h009a, "call high");
    run(OP_RTS, 8'h0, 24'h0, 32'h0, 3'h0, 1'b0);
    chk(res_o.pc === 24'h9abcde, "long return");
    run(OP_LDCCR, 8'h0, 24'h0, 32'h00000005, 3'h0, 1'b0);
    chk(ccr_o === 8'h05, "ccr load");
    run(OP_RTE, 8'h0, 24'h0, 32'h0, 3'h0, 1'b0);
    chk(ccr_o === 8'h80, "ccr restored");
    chk(res_o.pc === 24'h345678, "exception return");
    chk(sp_o === 32'h0, "sp after exception return");
    run(OP_JSR_IND, 8'h40, 24'h000200, 32'h0, 3'h0, 1'b0);
    chk(res_o.pc === 24'h123456, "indirect call");
    chk(mem[24'hfffffe] === 16'h0200, "indirect call low");
    chk(mem[24'hfffffc] === 16'h0000, "indirect call high");
    chk(advanced_o === 1'b1, "mode held");
    $display("advanced mode test over");
  endtask

  task automatic t_mul;
    cmal_op_type ops [4] = '{OP_UMUL_B, OP_UMUL_W, OP_SMUL_B, OP_SMUL_W};
    int st [4] = '{UMUL_B_STATES, UMUL_W_STATES, SMUL_B_STATES,
        SMUL_W_STATES};
    int k;
    for (int i = 0; i < 8; i++) begin
      speed_sel_i = i[2] ? 2'h1 : 2'h0;
      k = st[i % 4] << i[2];
      run(ops[i % 4], 8'h0, 24'h0, 32'h0, 3'h0, 1'b0);
      chk(n >= k && n <= k + 2, "multiply states");
    end
    speed_sel_i = 2'h0;
    $display("multiply test over");
  endtask

  task automatic t_sleep;
    fork
      run(OP_SLEEP, 8'h0, 24'h0, 32'h0, 3'h0, 1'b0);
      begin
        repeat (8) @(negedge sys_clk_i);
        chk(sleep_o === 1'b1 && res_o.done === 1'b0, "sleep");
        wake_i = 1'b1;
      end
    join
    wake_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(sleep_o === 1'b0, "wake");
    $display("sleep test over");
  endtask

  // main sequence
  initial begin
    t_normal;
    t_adv;
    t_mul;
    t_sleep;
    wrap_up;
  end

  // watchdog well past the expected run
  initial begin
    #200000;
    err_total++;
    $display("mismatch at %0t: watchdog", $time);
    wrap_up;
  end
endmodule
`default_nettype wire
